/* rtl/rtc_value_pkg.sv */
// Purpose: Shared constants for the calendar value block and its timebase prescaler
// Assumes: 16-bit value windows, 2-bit window pointers, 32768 timebase pulses per second
// Notes: All offsets, field positions, reset values and counts live here
package rtc_value_pkg;
    // Config/calibration register field positions
    localparam int CFG_EN_BIT = 15;
    localparam int CFG_WREN_BIT = 13;
    localparam int CFG_SYNC_BIT = 12;
    localparam int CFG_HALF_BIT = 11;
    localparam int CFG_OE_BIT = 10;
    localparam int CFG_PTR_LSB = 8;
    localparam int CFG_CAL_LSB = 0;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [1:0] PTR_RESET = 2'h0;

    // Window pointer codes
    localparam logic [1:0] PTR_MIN_SEC = 2'h0;
    localparam logic [1:0] PTR_WDHR = 2'h1;
    localparam logic [1:0] PTR_MONTH_DAY = 2'h2;
    localparam logic [1:0] PTR_YEAR = 2'h3;

    // Implemented bits of each value register; all others read as zero
    localparam logic [15:0] MASK_MIN_SEC = 16'h7F7F;
    localparam logic [15:0] MASK_WDHR = 16'h073F;
    localparam logic [15:0] MASK_MONTH_DAY = 16'h1F3F;
    localparam logic [15:0] MASK_YEAR = 16'h00FF;

    // Timebase counts per second, half point and read-sync window
    localparam logic signed [16:0] PULSES_PER_SEC = 17'sh08000;
    localparam logic signed [16:0] HALF_POINT = 17'sh04000;
    localparam logic signed [16:0] SYNC_WINDOW = 17'sh00020;
    localparam logic signed [16:0] COUNT_RESET = 17'sh00000;
    localparam int CAL_SHIFT = 2;

    // BCD limits of the calendar digits
    localparam logic [7:0] SEC_MAX = 8'h59;
    localparam logic [7:0] HOUR_MAX = 8'h23;
    localparam logic [7:0] WDAY_MAX = 8'h06;
    localparam logic [7:0] MONTH_MAX = 8'h12;
    localparam logic [7:0] YEAR_MAX = 8'h99;
    localparam logic [7:0] FIRST_DAY = 8'h01;
endpackage

/* rtl/second_tick_if.sv */
// Purpose: Carries timing strobes and calibration between the core and the prescaler
// Assumes: Single clock domain
// Notes: Core drives control, prescaler drives tick, half and sync
`timescale 1ns/1ps
`default_nettype none
interface second_tick_if;
    logic enable;
    logic [7:0] drift_trim_field;
    logic minute_edge;
    logic half_clear;
    logic sec_tick;
    logic half_second_flag;
    logic sync_window;

    modport core (output enable, output drift_trim_field, output minute_edge,
                  output half_clear, input sec_tick, input half_second_flag,
                  input sync_window);
    modport prescaler (input enable, input drift_trim_field, input minute_edge,
                       input half_clear, output sec_tick, output half_second_flag,
                       output sync_window);
endinterface
`default_nettype wire

/* rtl/drift_prescaler.sv */
// Purpose: Divides the timebase pulse into seconds and applies the minute drift trim
// Assumes: tick_32k_i is a one-cycle strobe synchronous to clock_i
// Notes: The trim is applied by the starting count of each new minute
`timescale 1ns/1ps
`default_nettype none
module drift_prescaler
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Timebase strobe
    input wire logic tick_32k_i,
    // Link to the calendar core
    second_tick_if.prescaler tb
);
    import rtc_value_pkg::*;

    logic signed [16:0] count_q;
    logic signed [16:0] count_d;
    logic last_pulse;
    logic half_q;
    logic sync_q;

    // Signed trim times four sets the start of the first second of a minute
    assign last_pulse = tb.enable && tick_32k_i && (count_q == PULSES_PER_SEC - 17'sh00001);
    assign count_d = tb.minute_edge
        ? 17'(signed'(tb.drift_trim_field) <<< CAL_SHIFT)
        : COUNT_RESET;
    assign tb.sec_tick = last_pulse;
    assign tb.half_second_flag = half_q;
    assign tb.sync_window = sync_q;

    // Pulse counter; it simply halts while the clock is disabled
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            count_q <= COUNT_RESET;
        else if (last_pulse)
            count_q <= count_d;
        else if (tb.enable && tick_32k_i)
            count_q <= count_q + 17'sh00001;
    end

    // Half-second flag: set on entering the second half, set beats a clear
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            half_q <= 1'b0;
        else if (tb.enable && tick_32k_i && count_q == HALF_POINT - 17'sh00001)
            half_q <= 1'b1;
        else if (last_pulse || tb.half_clear)
            half_q <= 1'b0;
    end

    // Warns readers that a rollover ripple is near
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            sync_q <= 1'b0;
        else
            sync_q <= tb.enable && (count_q >= PULSES_PER_SEC - SYNC_WINDOW);
    end

    a_minute_trim_load: assert property (@(posedge clock_i) disable iff (rst_i)
        last_pulse && tb.minute_edge |=>
        count_q == 17'($past(signed'(tb.drift_trim_field)) * 4))
        else $error("minute start count is not four times the trim");
    a_negative_trim: assert property (@(posedge clock_i) disable iff (rst_i)
        last_pulse && tb.minute_edge && tb.drift_trim_field[7] |=> count_q < 0)
        else $error("negative trim did not lengthen the minute");
    a_plain_second: assert property (@(posedge clock_i) disable iff (rst_i)
        last_pulse && !tb.minute_edge |=> count_q == COUNT_RESET)
        else $error("ordinary second did not restart from zero");
endmodule
`default_nettype wire

/* rtl/calendar_value_core.sv */
// Purpose: Calendar counters, alarm compare values and pointer-selected value windows
// Assumes: Software reaches values only through the config register and two windows
// Notes: Value fields other than the time month have no reset; they are undefined until software loads them
//
// What this block does
// - Year held as two BCD digits, low byte
// - Year writes ignored unless write enable set
// - Other value writes also need write enable
// - Month in bits 12 and 11-8, read-only
// - Day tens bits 5-4, ones bits 3-0
// - Weekday three bits 10-8, range 0-6
// - Hour tens bits 5-4, ones bits 3-0
// - Minutes in high byte, tens 14-12
// - Seconds in low byte, tens 6-4
// - Unimplemented value bits always read zero
// - Alarm month/day fully readable and writable
// - Alarm weekday/hour and minute/second mirror time layout
// - Trim times four applied once per minute
// - Negative trim adds pulses per minute
// - Two-bit pointer selects pair, decrements to zero
// - Positive trim removes pulses, up to 508
// - Low minute/second write clears half-second flag
`timescale 1ns/1ps
`default_nettype none
module calendar_value_core
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Timebase strobe
    input wire logic tick_32k_i,
    // Config and calibration register
    input wire logic cfg_wr_i,
    input wire logic [15:0] cfg_wdata_i,
    output logic [15:0] cfg_rdata_o,
    // Time value window
    input wire logic val_rd_i,
    input wire logic val_wr_i,
    input wire logic [1:0] val_be_i,
    input wire logic [15:0] val_wdata_i,
    output logic [15:0] val_rdata_o,
    // Alarm value window and its pointer
    input wire logic alm_ptr_wr_i,
    input wire logic [1:0] alm_ptr_i,
    output logic [1:0] alm_ptr_o,
    input wire logic alm_rd_i,
    input wire logic alm_wr_i,
    input wire logic [1:0] alm_be_i,
    input wire logic [15:0] alm_wdata_i,
    output logic [15:0] alm_rdata_o
);
    import rtc_value_pkg::*;

    second_tick_if tb ();

    logic enable_q;
    logic value_write_enable_q;
    logic output_enable_q;
    logic [1:0] value_window_pointer_q;
    logic [7:0] drift_trim_field_q;
    logic [1:0] alm_ptr_q;
    logic [15:0] val_rdata_q;
    logic [15:0] alm_rdata_q;
    logic [7:0] sec_q, min_q, hour_q, wday_q, day_q, month_q, year_q;
    logic [7:0] alm_sec_q, alm_min_q, alm_hour_q, alm_wday_q, alm_day_q, alm_month_q;
    logic val_wr_ok;
    logic alm_wr_ok;
    logic val_hi_wr;
    logic val_lo_wr;
    logic adv;
    logic sec_wrap, min_wrap, hour_wrap, day_wrap, month_wrap;
    logic [7:0] sec_n, min_n, hour_n, wday_n, day_n, month_n, year_n;
    logic [7:0] month_last;
    logic [15:0] val_sel;
    logic [15:0] alm_sel;

    // One BCD digit pair up by one
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    // Days in a month; two-digit year, so every fourth year is a leap year
    function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (mon)
            8'h02: month_len = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default: month_len = 8'h31;
        endcase
    endfunction

    drift_prescaler u_prescaler (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .tick_32k_i(tick_32k_i),
        .tb(tb)
    );

    // Writes through either window land only while the lock is open
    assign val_wr_ok = val_wr_i && value_write_enable_q;
    assign alm_wr_ok = alm_wr_i && value_write_enable_q;
    assign val_hi_wr = val_wr_ok && val_be_i[1];
    assign val_lo_wr = val_wr_ok && val_be_i[0];
    assign adv = tb.sec_tick;

    assign tb.enable = enable_q;
    assign tb.drift_trim_field = drift_trim_field_q;
    assign tb.minute_edge = (sec_q[6:0] == SEC_MAX[6:0]);
    assign tb.half_clear = val_lo_wr && value_window_pointer_q == PTR_MIN_SEC;

    // Config register readback; pointer and status come straight from flops
    always_comb
    begin
        cfg_rdata_o = 16'h0000;
        cfg_rdata_o[CFG_EN_BIT] = enable_q;
        cfg_rdata_o[CFG_WREN_BIT] = value_write_enable_q;
        cfg_rdata_o[CFG_SYNC_BIT] = tb.sync_window;
        cfg_rdata_o[CFG_HALF_BIT] = tb.half_second_flag;
        cfg_rdata_o[CFG_OE_BIT] = output_enable_q;
        cfg_rdata_o[CFG_PTR_LSB +: 2] = value_window_pointer_q;
        cfg_rdata_o[CFG_CAL_LSB +: 8] = drift_trim_field_q;
    end

    // Config fields; the enable bit only moves while the lock is open
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            enable_q <= CFG_RESET[CFG_EN_BIT];
            value_write_enable_q <= CFG_RESET[CFG_WREN_BIT];
            output_enable_q <= CFG_RESET[CFG_OE_BIT];
            drift_trim_field_q <= CFG_RESET[CFG_CAL_LSB +: 8];
        end
        else if (cfg_wr_i)
        begin
            if (value_write_enable_q)
                enable_q <= cfg_wdata_i[CFG_EN_BIT];
            value_write_enable_q <= cfg_wdata_i[CFG_WREN_BIT];
            output_enable_q <= cfg_wdata_i[CFG_OE_BIT];
            drift_trim_field_q <= cfg_wdata_i[CFG_CAL_LSB +: 8];
        end
    end

    // Time pointer: loaded by config write, else steps down to zero on a read or a high-byte write
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            value_window_pointer_q <= PTR_RESET;
        else if (cfg_wr_i)
            value_window_pointer_q <= cfg_wdata_i[CFG_PTR_LSB +: 2];
        else if ((val_rd_i || (val_wr_i && val_be_i[1])) && value_window_pointer_q != 2'h0)
            value_window_pointer_q <= value_window_pointer_q - 2'h1;
    end

    // Alarm pointer behaves the same way on its own window
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            alm_ptr_q <= PTR_RESET;
        else if (alm_ptr_wr_i)
            alm_ptr_q <= alm_ptr_i;
        else if ((alm_rd_i || (alm_wr_i && alm_be_i[1])) && alm_ptr_q != 2'h0)
            alm_ptr_q <= alm_ptr_q - 2'h1;
    end
    assign alm_ptr_o = alm_ptr_q;

    // Next calendar values for a one-second advance
    always_comb
    begin
        sec_wrap = (sec_q[6:0] == SEC_MAX[6:0]);
        min_wrap = sec_wrap && (min_q[6:0] == SEC_MAX[6:0]);
        hour_wrap = min_wrap && (hour_q[5:0] == HOUR_MAX[5:0]);
        month_last = month_len(month_q & 8'h1F, year_q);
        day_wrap = hour_wrap && (day_q[5:0] == month_last[5:0]);
        month_wrap = day_wrap && (month_q[4:0] == MONTH_MAX[4:0]);
        sec_n = sec_wrap ? 8'h00 : bcd_inc(sec_q);
        min_n = (min_q[6:0] == SEC_MAX[6:0]) ? 8'h00 : bcd_inc(min_q);
        hour_n = (hour_q[5:0] == HOUR_MAX[5:0]) ? 8'h00 : bcd_inc(hour_q);
        wday_n = (wday_q[2:0] == WDAY_MAX[2:0]) ? 8'h00 : wday_q + 8'h01;
        day_n = day_wrap ? FIRST_DAY : bcd_inc(day_q);
        month_n = month_wrap ? FIRST_DAY : bcd_inc(month_q);
        year_n = (year_q == YEAR_MAX) ? 8'h00 : bcd_inc(year_q);
    end

    // Time digits: advance on the second, then accepted writes override the
    // written byte so a readback shows the implemented bits that software wrote
    always_ff @(posedge clock_i)
    begin
        if (adv)
        begin
            sec_q <= sec_n;
            if (sec_wrap)
                min_q <= min_n;
            if (min_wrap)
                hour_q <= hour_n;
            if (hour_wrap)
            begin
                wday_q <= wday_n;
                day_q <= day_n;
            end
            if (month_wrap)
                year_q <= year_n;
        end
        case (value_window_pointer_q)
            PTR_MIN_SEC:
            begin
                if (val_hi_wr)
                    min_q <= {1'b0, val_wdata_i[14:8]};
                if (val_lo_wr)
                    sec_q <= {1'b0, val_wdata_i[6:0]};
            end
            PTR_WDHR:
            begin
                if (val_hi_wr)
                    wday_q <= {5'h00, val_wdata_i[10:8]};
                if (val_lo_wr)
                    hour_q <= {2'h0, val_wdata_i[5:0]};
            end
            PTR_MONTH_DAY:
            begin
                // Month byte is read-only here, so only the day lands
                if (val_lo_wr)
                    day_q <= {2'h0, val_wdata_i[5:0]};
            end
            default:
            begin
                if (val_lo_wr)
                    year_q <= val_wdata_i[7:0];
            end
        endcase
    end

    // Month has no write path through the time window, so it starts from
    // January rather than staying unknown and poisoning the day rollover
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            month_q <= FIRST_DAY;
        else if (adv && day_wrap)
            month_q <= month_n;
    end

    // Alarm compare values, same layouts as the time registers
    always_ff @(posedge clock_i)
    begin
        if (alm_wr_ok)
        begin
            case (alm_ptr_q)
                PTR_MIN_SEC:
                begin
                    if (alm_be_i[1])
                        alm_min_q <= {1'b0, alm_wdata_i[14:8]};
                    if (alm_be_i[0])
                        alm_sec_q <= {1'b0, alm_wdata_i[6:0]};
                end
                PTR_WDHR:
                begin
                    if (alm_be_i[1])
                        alm_wday_q <= {5'h00, alm_wdata_i[10:8]};
                    if (alm_be_i[0])
                        alm_hour_q <= {2'h0, alm_wdata_i[5:0]};
                end
                PTR_MONTH_DAY:
                begin
                    if (alm_be_i[1])
                        alm_month_q <= {3'h0, alm_wdata_i[12:8]};
                    if (alm_be_i[0])
                        alm_day_q <= {2'h0, alm_wdata_i[5:0]};
                end
                default:
                begin
                end
            endcase
        end
    end

    // Window read selection; unimplemented positions masked to zero
    always_comb
    begin
        case (value_window_pointer_q)
            PTR_MIN_SEC: val_sel = {min_q, sec_q} & MASK_MIN_SEC;
            PTR_WDHR: val_sel = {wday_q, hour_q} & MASK_WDHR;
            PTR_MONTH_DAY: val_sel = {month_q, day_q} & MASK_MONTH_DAY;
            default: val_sel = {8'h00, year_q} & MASK_YEAR;
        endcase
        case (alm_ptr_q)
            PTR_MIN_SEC: alm_sel = {alm_min_q, alm_sec_q} & MASK_MIN_SEC;
            PTR_WDHR: alm_sel = {alm_wday_q, alm_hour_q} & MASK_WDHR;
            PTR_MONTH_DAY: alm_sel = {alm_month_q, alm_day_q} & MASK_MONTH_DAY;
            default: alm_sel = 16'h0000;
        endcase
    end

    // Read data is captured from the pointer seen at the read cycle
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            val_rdata_q <= 16'h0000;
            alm_rdata_q <= 16'h0000;
        end
        else
        begin
            if (val_rd_i)
                val_rdata_q <= val_sel;
            if (alm_rd_i)
                alm_rdata_q <= alm_sel;
        end
    end
    assign val_rdata_o = val_rdata_q;
    assign alm_rdata_o = alm_rdata_q;

    a_year_write_lock: assert property (@(posedge clock_i) disable iff (rst_i)
        val_wr_i && !value_write_enable_q && val_be_i[0] && !adv
        && value_window_pointer_q == PTR_YEAR |=> $stable(year_q))
        else $error("locked year write changed the year");
    a_year_write_lands: assert property (@(posedge clock_i) disable iff (rst_i)
        val_lo_wr && value_window_pointer_q == PTR_YEAR |=> year_q == $past(val_wdata_i[7:0]))
        else $error("accepted year write did not land");
    a_month_read_only: assert property (@(posedge clock_i) disable iff (rst_i)
        val_hi_wr && !adv && value_window_pointer_q == PTR_MONTH_DAY |=> $stable(month_q))
        else $error("month changed by a software write");
    a_unimpl_bits_zero: assert property (@(posedge clock_i) disable iff (rst_i)
        val_rd_i && value_window_pointer_q == PTR_MIN_SEC |=>
        val_rdata_o[15] == 1'b0 && val_rdata_o[7] == 1'b0)
        else $error("unimplemented minute/second bit read as one");
    a_pointer_steps_down: assert property (@(posedge clock_i) disable iff (rst_i)
        val_rd_i && !cfg_wr_i && value_window_pointer_q != 2'h0 |=>
        value_window_pointer_q == $past(value_window_pointer_q) - 2'h1)
        else $error("pointer did not step down after a read");
    a_half_flag_clear: assert property (@(posedge clock_i) disable iff (rst_i)
        tb.half_clear && tb.half_second_flag |=> !tb.half_second_flag)
        else $error("half-second flag survived a low minute/second write");
    a_second_advance: assert property (@(posedge clock_i) disable iff (rst_i)
        adv && sec_q == 8'h59 && min_q == 8'h09 && !val_wr_i |=>
        sec_q == 8'h00 && min_q == 8'h10)
        else $error("minute did not carry into its tens digit");
    a_alarm_day_write: assert property (@(posedge clock_i) disable iff (rst_i)
        alm_wr_ok && alm_be_i == 2'h3 && alm_ptr_q == PTR_MONTH_DAY |=>
        {alm_month_q[4:0], alm_day_q[5:0]} ==
        {$past(alm_wdata_i[12:8]), $past(alm_wdata_i[5:0])})
        else $error("alarm month/day write did not land");
endmodule
`default_nettype wire

/* dv/test_calendar_value_core.sv */
// Purpose: Self-checking bench of the calendar value core against a bench model
// Assumes: Timebase strobe held high, so one second lasts 32768 clocks
// Notes: Month cannot be written, so it must read back as January throughout
`timescale 1ns/1ps
`default_nettype none
module test_calendar_value_core;
    import rtc_value_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic tick_32k_i = 1'b0;
    logic cfg_wr_i = 1'b0;
    logic [15:0] cfg_wdata_i = 16'h0000;
    logic [15:0] cfg_rdata_o;
    logic [1:0] rd = 2'h0;
    logic [1:0] wr = 2'h0;
    logic [1:0] be = 2'h0;
    logic [15:0] wd = 16'h0000;
    logic [15:0] val_rdata_o;
    logic [15:0] alm_rdata_o;
    logic ptr_wr = 1'b0;
    logic [1:0] ptr_in = 2'h0;
    logic [1:0] alm_ptr_o;
    // Model: contents of both windows, their pointers and the write lock
    logic [15:0] em [2][4] = '{default: 16'h0000};
    int ep [2] = '{0, 0};
    logic lk = 1'b0;
    int seed = 32'heaee;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t0 = 0;

    calendar_value_core u_dut (
        .clock_i(clock_i), .rst_i(rst_i), .tick_32k_i(tick_32k_i),
        .cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
        .val_rd_i(rd[0]), .val_wr_i(wr[0]), .val_be_i(be), .val_wdata_i(wd),
        .val_rdata_o(val_rdata_o), .alm_ptr_wr_i(ptr_wr), .alm_ptr_i(ptr_in),
        .alm_ptr_o(alm_ptr_o), .alm_rd_i(rd[1]), .alm_wr_i(wr[1]), .alm_be_i(be),
        .alm_wdata_i(wd), .alm_rdata_o(alm_rdata_o)
    );

    // Free-running 200 MHz clock
    always #2.5 clock_i = ~clock_i;

    // Hang guard; the tests need a little under 99000 cycles
    always @(posedge clock_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 110000)
        begin
            n_fail++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    function automatic logic [15:0] mk(input int p);
        return p == 0 ? MASK_MIN_SEC : p == 1 ? MASK_WDHR : p == 2 ? MASK_MONTH_DAY : MASK_YEAR;
    endfunction

    function automatic int rn(input int n);
        return $unsigned($random(seed)) % n;
    endfunction

    // Legal digits, with every unimplemented bit set so it must read back zero
    function automatic logic [15:0] gen(input int p);
        logic [15:0] v;
        v = {1'b0, 3'(rn(6)), 4'(rn(10)), 1'b0, 3'(rn(6)), 4'(rn(10))};
        if (p == 1) v = {5'h0, 3'(rn(7)), 2'h0, 2'(rn(2)), 4'(rn(10))};
        if (p == 2) v = {4'h0, 4'(rn(9) + 1), 2'h0, 2'(rn(3)), 4'(rn(10))};
        if (p == 3) v = {8'h00, 4'(rn(10)), 4'(rn(10))};
        return v | ~mk(p);
    endfunction

    task automatic cw(input logic [15:0] d);
        @(posedge clock_i);
        cfg_wr_i <= 1'b1;
        cfg_wdata_i <= d;
        @(posedge clock_i);
        cfg_wr_i <= 1'b0;
        #1;
        lk = d[CFG_WREN_BIT];
        ep[0] = d[9:8];
    endtask

    task automatic ld(input logic [1:0] p);
        @(posedge clock_i);
        ptr_wr <= 1'b1;
        ptr_in <= p;
        @(posedge clock_i);
        ptr_wr <= 1'b0;
        #1;
        ep[1] = p;
    endtask

    // One window access; the model follows the lock, read-only bytes and pointer walk
    task automatic acc(input int a, input bit w, input logic [1:0] b, input logic [15:0] d);
        int p;
        logic [15:0] g;
        logic [15:0] mv;
        p = ep[a];
        mv = mk(p);
        @(posedge clock_i);
        rd[a] <= !w;
        wr[a] <= w;
        be <= b;
        wd <= d;
        @(posedge clock_i);
        rd <= 2'h0;
        wr <= 2'h0;
        #1;
        g = a ? alm_rdata_o : val_rdata_o;
        if (!w)
            chk(em[a][p], g);
        if (w && lk && b[0] && !(a == 1 && p == 3))
            em[a][p][7:0] = d[7:0] & mv[7:0];
        if (w && lk && b[1] && (p < 2 || (a == 1 && p == 2)))
            em[a][p][15:8] = d[15:8] & mv[15:8];
        if ((!w || b[1]) && p > 0)
            ep[a] = p - 1;
        chk(16'(ep[a]), 16'(a ? alm_ptr_o : cfg_rdata_o[9:8]));
    endtask

    // Load every pair through both windows, then read all back as the pointers walk
    task automatic sweep(input logic l);
        cw({2'h0, l, 5'h03, 8'h00});
        for (int p = 3; p >= 0; p--)
            acc(0, 1'b1, 2'h3, gen(p));
        ld(2'h2);
        for (int p = 2; p >= 0; p--)
            acc(1, 1'b1, 2'h3, gen(p));
        cw({2'h0, l, 5'h03, 8'h00});
        ld(2'h3);
        repeat (5)
        begin
            acc(0, 1'b0, 2'h0, 16'h0000);
            acc(1, 1'b0, 2'h0, 16'h0000);
        end
    endtask

    task automatic wt(input logic v);
        int k;
        k = 0;
        while (cfg_rdata_o[CFG_SYNC_BIT] !== v && k < 40000)
        begin
            @(posedge clock_i);
            #1;
            k++;
        end
    endtask

    // Time from a sync fall to the next sync rise, the second less its window; one clock of slack for the wrap edge
    task automatic near(input int e);
        int d;
        d = cyc - t0;
        chk(16'(e), 16'((d - e) inside {[-1:1]} ? e : d));
    endtask

    initial
    begin
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        tick_32k_i <= 1'b1;
        #1;
        chk(16'h0000, cfg_rdata_o);
        chk(16'h0000, val_rdata_o | alm_rdata_o);
        em[0][2] = {FIRST_DAY, 8'h00};
        sweep(1'b1);
        $display("test load_and_walk done");
        sweep(1'b0);
        $display("test write_lock done");
        // Enable with top trim, then watch the half flag and its clear
        cw(16'h2000);
        acc(0, 1'b1, 2'h3, 16'h0959);
        cw(16'hA07F);
        repeat (16400) @(posedge clock_i);
        #1;
        chk(16'h0800, cfg_rdata_o & 16'h1800);
        acc(0, 1'b1, 2'h1, 16'h0959);
        chk(16'h0000, cfg_rdata_o & 16'h1800);
        wt(1'b1);
        wt(1'b0);
        t0 = cyc;
        em[0][0] = 16'h1000;
        acc(0, 1'b0, 2'h0, 16'h0000);
        acc(0, 1'b1, 2'h1, 16'h0059);
        cw(16'hA080);
        chk(16'hA080, cfg_rdata_o & 16'hA0FF);
        wt(1'b1);
        near(32736 - 508);
        wt(1'b0);
        t0 = cyc;
        em[0][0] = 16'h1100;
        acc(0, 1'b0, 2'h0, 16'h0000);
        wt(1'b1);
        near(32736 + 512);
        $display("test timebase_trim done");
        test_done();
    end
endmodule
`default_nettype wire
